// file: rtl/sbam_pkg.sv
// Shared constants and types for the burst address mapper.
package sbam_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int FRONT_CYCLES  = 3;
  localparam int CAS_CYCLES    = 2;
  localparam int BEATS         = 4;
  localparam int ADDR_OUT_W    = 19;
  localparam int AHB_ADDR_W    = 32;
  localparam int DATA_W        = 64;
  localparam int NUM_CS        = 4;
  localparam int AP_BIT_SDR    = 10;
  localparam int AP_BIT_DDR32  = 8;
  localparam int BANK_BIT_OUT  = 13;
  localparam int BANK_BIT_AHB  = 21;

  // Address map select codes.
  localparam logic [1:0] MAP_BRC   = 2'h0;
  localparam logic [1:0] MAP_RBC   = 2'h1;
  localparam logic [1:0] MAP_FLASH = 2'h2;
  // Data bus width codes.
  localparam logic [1:0] BUS_16 = 2'h0;
  localparam logic [1:0] BUS_32 = 2'h1;
  localparam logic [1:0] BUS_64 = 2'h2;

  typedef enum logic [1:0] {
    PH_ROW,
    PH_BANK,
    PH_COL
  } sbam_phase_e;
endpackage : sbam_pkg

// file: rtl/sbam_addr_mux.sv
// Combinational address multiplexer for row, bank and column phases.
`timescale 1ns/1ps
module sbam_addr_mux (
  input  wire logic [31:0] ahb_addr,
  input  wire logic [1:0]  address_map_select,
  input  wire logic [1:0]  bus_width,
  input  wire logic        is_ddr,
  input  wire logic [1:0]  phase,
  input  wire logic [1:0]  sub_beat,
  input  wire logic        precharge,
  output logic      [18:0] addr,
  output logic             auto_precharge_bit
);
  logic [18:0] row_a;
  logic [18:0] bank_a;
  logic [18:0] col_a;
  logic [1:0]  grp;
  logic [2:0]  seg;
  logic [10:0] col_hi;

  // Scheme decides where the bank bits are taken from.
  assign grp = (address_map_select == sbam_pkg::MAP_RBC) ? ahb_addr[11:10] : ahb_addr[22:21];
  assign seg = ahb_addr[25:23];
  assign col_hi = ahb_addr[14:4];
  // Row and bank lines; bank sits on A13/A14, segments on A15..A17.
  assign row_a = {6'h00, ahb_addr[24:12]};
  assign bank_a = (address_map_select == sbam_pkg::MAP_FLASH) ?
                  {1'b0, seg, grp, 13'h0000} : {4'h0, grp, 13'h0000};
  // Low column bits come from the sub-beat counter, not from the bus.
  always_comb begin
    col_a = {8'h00, col_hi};
    unique case (bus_width)
      sbam_pkg::BUS_16: col_a = {6'h00, col_hi, sub_beat};
      sbam_pkg::BUS_32: col_a = {7'h00, col_hi, sub_beat[0]};
      default:          col_a = {8'h00, col_hi};
    endcase
  end
  // Auto precharge rides A8 for 32-bit DDR, otherwise A10 outside the row phase.
  assign auto_precharge_bit = precharge;
  always_comb begin
    addr = row_a;
    unique case (phase)
      2'h0:    addr = row_a;
      2'h1:    addr = bank_a | row_a;
      default: addr = col_a | bank_a;
    endcase
    if (is_ddr && bus_width == sbam_pkg::BUS_32) begin
      addr[sbam_pkg::AP_BIT_DDR32] = precharge;
    end else if (phase != 2'h0) begin
      addr[sbam_pkg::AP_BIT_SDR] = precharge;
    end
  end
endmodule : sbam_addr_mux

// file: rtl/sdram_burst_addr_map.sv
// Open-row burst sequencer with address mapping for SDR memory.
// How it works
// - Read command issues fourth cycle after AHB address, three front-end cycles.
// - Two cycles of CAS latency, then first read beat is captured.
// - Four beats captured back to back, each forwarded one cycle later.
// - Second read address accepted on last beat return; full front end repeats.
// - Write data taken in second cycle; four beats driven from fourth cycle.
// - Second write accepted during first burst; beats follow with no gap.
// - Per chip select map field picks how AHB address maps to 19 lines.
// - Column and bank bits driven together in the column phase only; row bits never driven.
// - Low column bits generated internally to step sub-beats on 16- and 32-bit buses; none on the fixed 64-bit bus.
// - 32-bit bus uses two sub-beats, lowest column bit 0 then 1.
// - 16-bit bus uses four sub-beats, column bits 00 to 11.
// - Auto precharge on A8 for 32-bit DDR, A10 otherwise.
// - Separate auto precharge output drives memory precharge input.
// - Bank-row-column, row-bank-column and segmented flash schemes supported.
// - Flash scheme drives up to three segment lines beside bank lines.
// - Sample 16M map puts AHB bit 21 on A13 and precharge on A10.
`timescale 1ns/1ps
module sdram_burst_addr_map #(
  parameter int FRONT = sbam_pkg::FRONT_CYCLES,
  parameter int CAS   = sbam_pkg::CAS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [1:0]  req_cs,
  output logic             req_ready,
  input  wire logic [63:0] wr_data,
  input  wire logic        wr_valid,
  input  wire logic [7:0]  dynamic_chip_config,
  output logic [63:0]      rd_data,
  output logic             rd_valid,
  output logic [18:0]      memory_address_out,
  output logic             auto_precharge_out,
  output logic             mem_read_cmd,
  output logic             mem_write_cmd,
  output logic [63:0]      mem_wr_data,
  input  wire logic [63:0] mem_rd_data
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FRONT,
    ST_CAS,
    ST_RDATA,
    ST_WDATA
  } sbam_state_e;

  sbam_state_e st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [31:0] addr_q;
  logic [1:0]  cs_q;
  logic        wr_q;
  logic [63:0] wbuf_q;
  logic        pend_q;
  logic [31:0] paddr_q;
  logic [1:0]  pcs_q;
  logic [63:0] pdata_q;
  logic [63:0] rd_data_q;
  logic        rd_valid_q;
  logic [18:0] mao_q;
  logic        ap_q;
  logic        rcmd_q;
  logic        wcmd_q;
  logic [63:0] mwd_q;
  logic [18:0] mux_addr;
  logic        mux_ap;
  logic [1:0]  cfg_map;
  logic [1:0]  cfg_bw;
  logic        cfg_ddr;
  logic        take;
  logic        front_done;
  logic        last_beat;
  logic        overlap_ok;
  logic        promote;
  logic        rd_beat;
  logic [1:0]  mux_phase;

  // Each chip select holds a 2-bit config: map in bits [2cs+1:2cs] of the config byte.
  function automatic logic [1:0] cfg_field(input logic [7:0] cfg, input logic [1:0] cs);
    cfg_field = cfg[{cs, 1'b0} +: 2];
  endfunction : cfg_field

  assign cfg_map    = cfg_field(dynamic_chip_config, cs_q);
  assign cfg_bw     = sbam_pkg::BUS_64;
  assign cfg_ddr    = 1'b0;
  // A read is taken only once the last beat has gone out, so the front end runs again.
  // A write may overlap on the first beat alone, which leaves time to park its data.
  assign take       = req_valid && req_ready;
  assign overlap_ok = (st_q == ST_WDATA) && (cnt_q == 4'h0) && !pend_q && wr_q;
  assign req_ready  = (st_q == ST_IDLE) || (overlap_ok && req_write);
  assign front_done = (st_q == ST_FRONT) && (cnt_q == 4'(FRONT - 1));
  assign last_beat  = cnt_q == 4'(sbam_pkg::BEATS - 1);
  assign promote    = (st_q == ST_WDATA) && last_beat && pend_q;
  assign rd_beat    = (st_q == ST_RDATA);
  // Open-row hits need only the column phase; the activate path would use the others.
  assign mux_phase  = sbam_pkg::PH_COL;

  // No auto precharge is asked for on open-row hits, so the dedicated line stays low.

  sbam_addr_mux u_mux (
    .ahb_addr           (addr_q),
    .address_map_select (cfg_map),
    .bus_width          (cfg_bw),
    .is_ddr             (cfg_ddr),
    .phase              (mux_phase),
    .sub_beat           (cnt_q[1:0]),
    .precharge          (1'b0),
    .addr               (mux_addr),
    .auto_precharge_bit (mux_ap)
  );

  // The beat counter is cleared on every state change and at each burst end, held at zero in idle, and counts up otherwise.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 4'h1;
    unique case (st_q)
      ST_IDLE: begin
        cnt_d = 4'h0;
        if (take) st_d = ST_FRONT;
      end
      ST_FRONT: if (front_done) begin
        cnt_d = 4'h0;
        st_d  = wr_q ? ST_WDATA : ST_CAS;
      end
      ST_CAS: if (cnt_q == 4'(CAS)) begin
        cnt_d = 4'h0;
        st_d  = ST_RDATA;
      end
      ST_RDATA: if (last_beat) begin
        cnt_d = 4'h0;
        st_d  = ST_IDLE;
      end
      ST_WDATA: if (last_beat) begin
        cnt_d = 4'h0;
        st_d  = pend_q ? ST_WDATA : ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      addr_q <= 32'h0000_0000;
      cs_q <= 2'h0;
      wr_q <= 1'b0;
      wbuf_q <= 64'h0;
      pend_q <= 1'b0;
      paddr_q <= 32'h0000_0000;
      pcs_q <= 2'h0;
      pdata_q <= 64'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      if (take && st_q != ST_WDATA) begin
        addr_q <= req_addr;
        cs_q <= req_cs;
        wr_q <= req_write;
      end
      if (wr_valid && st_q == ST_FRONT) wbuf_q <= wr_data;
      // Overlapped write is parked, then promoted at the first burst's end.
      if (take && st_q == ST_WDATA) begin
        pend_q <= 1'b1;
        paddr_q <= req_addr;
        pcs_q <= req_cs;
      end else if (promote) begin
        pend_q <= 1'b0;
        addr_q <= paddr_q;
        cs_q <= pcs_q;
        wbuf_q <= pdata_q;
      end
      if (wr_valid && pend_q) pdata_q <= wr_data;
    end
  end

  // Output stage: command, address and data all come from flip-flops.
  // Command and address share one edge; the first beat after a promotion still carries the first burst's address.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mao_q <= 19'h00000;
      ap_q <= 1'b0;
      rcmd_q <= 1'b0;
      wcmd_q <= 1'b0;
    end else begin
      rcmd_q <= front_done && !wr_q;
      wcmd_q <= (st_d == ST_WDATA);
      mao_q <= mux_addr;
      ap_q <= mux_ap;
    end
  end

  // On a promotion edge the parked word goes out at once, or the first beat would be stale.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mwd_q <= 64'h0;
    end else begin
      mwd_q <= promote ? pdata_q : wbuf_q;
    end
  end

  // Each beat is captured and handed to the bus side by one register, a cycle later.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_data_q <= 64'h0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_beat;
      if (rd_beat) rd_data_q <= mem_rd_data;
    end
  end

  assign memory_address_out = mao_q;
  assign auto_precharge_out = ap_q;
  assign mem_read_cmd       = rcmd_q;
  assign mem_write_cmd      = wcmd_q;
  assign mem_wr_data        = mwd_q;
  assign rd_data            = rd_data_q;
  assign rd_valid           = rd_valid_q;
endmodule : sdram_burst_addr_map

// file: tb/sbam_sva.sv
// Assertions on burst timing at the mapper ports.
`timescale 1ns/1ps
module sbam_sva #(
  parameter int FRONT = 3,
  parameter int CAS   = 2
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic        req_ready,
  input wire logic        rd_valid,
  input wire logic [63:0] rd_data,
  input wire logic        mem_read_cmd,
  input wire logic        mem_write_cmd,
  input wire logic [63:0] mem_rd_data
);
  localparam int D_CMD  = FRONT + 1;
  localparam int D_BEAT = FRONT + CAS + 3;
  wire logic rt = req_valid && req_ready && !req_write;
  wire logic wt = req_valid && req_ready && req_write;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_cmd; rt |-> ##D_CMD mem_read_cmd; endproperty
  a_cmd: assert property (p_cmd) else $error("read cmd late");
  property p_front; rt |-> ##1 !mem_read_cmd [*3]; endproperty
  a_front: assert property (p_front) else $error("read cmd early");
  property p_cas; mem_read_cmd |-> ##1 !rd_valid [*3] ##1 rd_valid; endproperty
  a_cas: assert property (p_cas) else $error("cas wait");
  property p_beats; rt |-> ##D_BEAT rd_valid [*4] ##1 !rd_valid; endproperty
  a_beats: assert property (p_beats) else $error("read beats");
  property p_fwd; rd_valid |-> rd_data == $past(mem_rd_data); endproperty
  a_fwd: assert property (p_fwd) else $error("beat forward");
  property p_busy; rt |-> ##1 !req_ready [*8]; endproperty
  a_busy: assert property (p_busy) else $error("read overlap");
  property p_wr; wt |-> ##D_CMD mem_write_cmd [*4]; endproperty
  a_wr: assert property (p_wr) else $error("write beats");
  property p_excl; mem_write_cmd |-> !mem_read_cmd; endproperty
  a_excl: assert property (p_excl) else $error("cmd clash");
  c_rd: cover property (rt);
  c_wr: cover property (wt);
  c_wr8: cover property (mem_write_cmd [*8]);
endmodule : sbam_sva

// file: tb/sbam_mem.sv
// Memory model returning four read beats after the CAS wait.
`timescale 1ns/1ps
module sbam_mem #(
  parameter int CAS = 2
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        mem_read_cmd,
  output logic      [63:0] mem_rd_data
);
  logic [3:0] n_q = 4'h0;
  wire logic  slot = n_q >= 4'(CAS) && n_q < 4'(CAS + 4);
  initial mem_rd_data = 64'h0;
  // Outside its slots the bus toggles, so a late capture cannot pass by luck.
  always @(posedge clk) begin
    if (!nrst || n_q == 4'(CAS + 4)) n_q <= 4'h0;
    else if (mem_read_cmd) n_q <= 4'h1;
    else if (n_q != 4'h0) n_q <= n_q + 4'h1;
    if (slot) mem_rd_data <= {60'hCAFE00000000000, n_q - 4'(CAS)};
    else mem_rd_data <= ~mem_rd_data;
  end
endmodule : sbam_mem

// file: tb/testbench.sv
// Self-checking bench for the burst address mapper.
`timescale 1ns/1ps
module testbench;
  logic        clk, nrst, req_valid, req_write, wr_valid, req_ready, rd_valid;
  logic        mem_read_cmd, mem_write_cmd, ap_out;
  logic [18:0] mem_addr;
  logic [19:0] ma[$];
  logic [1:0]  req_cs;
  logic [7:0]  dynamic_chip_config;
  logic [31:0] req_addr;
  logic [63:0] wr_data, rd_data, mem_rd_data, mem_wr;
  int          errors = 0, comparisons = 0, cyc = 0;
  int          tk[$], rc[$], rv[$], wc[$];
  logic [63:0] rd[$], wd[$];
  sdram_burst_addr_map #(.FRONT(sbam_pkg::FRONT_CYCLES), .CAS(sbam_pkg::CAS_CYCLES)) uut (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_cs(req_cs), .req_ready(req_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .dynamic_chip_config(dynamic_chip_config), .rd_data(rd_data),
    .rd_valid(rd_valid), .memory_address_out(mem_addr), .auto_precharge_out(ap_out),
    .mem_read_cmd(mem_read_cmd), .mem_write_cmd(mem_write_cmd), .mem_wr_data(mem_wr),
    .mem_rd_data(mem_rd_data));
  sbam_mem #(.CAS(sbam_pkg::CAS_CYCLES)) mem (.clk(clk), .nrst(nrst),
    .mem_read_cmd(mem_read_cmd), .mem_rd_data(mem_rd_data));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req_valid && req_ready === 1'b1) tk.push_back(cyc);
    if (mem_read_cmd === 1'b1) rc.push_back(cyc);
    if (mem_read_cmd === 1'b1) ma.push_back({ap_out, mem_addr});
    if (mem_write_cmd === 1'b1) wc.push_back(cyc);
    if (mem_write_cmd === 1'b1) wd.push_back(mem_wr);
    if (rd_valid === 1'b1) rv.push_back(cyc);
    if (rd_valid === 1'b1) rd.push_back(rd_data);
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until taken; a read leaves it up for a chained read.
  task automatic send(input logic w, input logic [31:0] a, input logic [63:0] d);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_cs = a[1:0];
    for (int i = 0; i < 40 && req_ready !== 1'b1; i++) @(posedge clk) #1;
    if (req_ready !== 1'b1) errors++;
    @(posedge clk) #1;
    if (w) begin
      req_valid = 1'b0;
      wr_valid = 1'b1;
      wr_data = d;
      @(posedge clk) #1;
      wr_valid = 1'b0;
    end
  endtask : send
  task automatic rd_pair;
    send(1'b0, 32'h0020_1000, 64'h0);
    send(1'b0, 32'h0000_2001, 64'h0);
    req_valid = 1'b0;
    repeat (25) @(posedge clk);
    #1;
    chk(tk[1] - tk[0], 11);
    chk(rc[0] - tk[0], 4);
    chk(rc[1] - tk[1], 4);
    chk(rv.size(), 8);
    chk(ma[0][13], 1);
    chk(ma[0][10], ma[0][19]);
    for (int k = 0; k < 8; k++) begin
      chk(rv[k] - tk[k / 4], 8 + k % 4);
      chk(rd[k], {60'hCAFE00000000000, 4'(k % 4)});
    end
  endtask : rd_pair
  task automatic wr_pair;
    tk.delete();
    send(1'b1, 32'h0000_3002, 64'h1111_2222_3333_4444);
    repeat (2) @(posedge clk);
    #1;
    send(1'b1, 32'h0000_3020, 64'h5555_6666_7777_8888);
    repeat (15) @(posedge clk);
    #1;
    chk(wc.size(), 8);
    chk(wc[0] - tk[0], 4);
    chk(wc[7] - wc[0], 7);
    chk(wd[0], 64'h1111_2222_3333_4444);
    chk(wd[3], 64'h1111_2222_3333_4444);
    chk(wd[4], 64'h5555_6666_7777_8888);
    chk(tk[1] - tk[0], 4);
    chk(rc.size(), 2);
  endtask : wr_pair
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    {nrst, req_valid, req_write, wr_valid} = 4'h0;
    req_cs = 2'h0;
    req_addr = 32'h0;
    wr_data = 64'h0;
    dynamic_chip_config = 8'h24;
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    rd_pair();
    wr_pair();
    complete_run();
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : testbench
bind sdram_burst_addr_map sbam_sva #(.FRONT(FRONT), .CAS(CAS)) u_sva (.clk(clk), .nrst(nrst),
  .req_valid(req_valid), .req_write(req_write), .req_ready(req_ready), .rd_valid(rd_valid),
  .rd_data(rd_data), .mem_read_cmd(mem_read_cmd), .mem_write_cmd(mem_write_cmd),
  .mem_rd_data(mem_rd_data));
